// ==== logic/dmscr_pkg.sv ====
`default_nettype none
package dmscr_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_DIAG_SRC    = 8'h24;
  localparam logic [7:0] OFF_SUPPLY_MON  = 8'h25;
  localparam logic [7:0] OFF_AMP_GAIN    = 8'h26;
  localparam logic [7:0] OFF_AMP1_BLANK  = 8'h27;
  localparam logic [7:0] OFF_CONTROL     = 8'h40;
  localparam logic [7:0] OFF_FAULT_STAT  = 8'h41;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h42;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h43;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_DIAG_SRC    = 8'h00;
  localparam logic [7:0] RST_SUPPLY_MON  = 8'h14;
  localparam logic [7:0] RST_AMP_GAIN    = 8'h09;
  localparam logic [7:0] RST_AMP1_BLANK  = 8'h00;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [3:0] RST_IRQ         = 4'h0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SUPPLY_UV_RESP_BIT   = 7;
  localparam int SUPPLY_OV_RESP_LSB   = 5;
  localparam int SUPPLY_OV_DG_LSB     = 3;
  localparam int SUPPLY_OV_THR_BIT    = 2;
  localparam int PUMP_UV_RESP_BIT     = 1;
  localparam int PUMP_UV_THR_BIT      = 0;
  localparam int AMP1_DIV_BIT         = 5;
  localparam int AMP1_GAIN_LSB        = 3;
  localparam int AMP2_DIV_BIT         = 2;
  localparam int AMP2_GAIN_LSB        = 0;
  localparam int BLANK_SEL_LSB        = 3;
  localparam int BLANK_LVL_LSB        = 0;
  localparam int CTRL_DIAG_EN_BIT     = 0;
  localparam int CTRL_FAULT_CLR_BIT   = 1;
  localparam logic [7:0] AMP_WR_MASK  = 8'h3F;
  localparam logic [7:0] BLANK_WR_MASK = 8'h3F;

  // Overvoltage response codes
  localparam logic [1:0] OV_LATCHED   = 2'h0;
  localparam logic [1:0] OV_AUTO      = 2'h1;
  localparam logic [1:0] OV_WARN      = 2'h2;
  localparam logic [1:0] OV_OFF       = 2'h3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int OV_DG0_US      = 1;
  localparam int OV_DG1_US      = 2;
  localparam int OV_DG2_US      = 4;
  localparam int OV_DG3_US      = 8;
  localparam int UV_DG_CYCLES   = 1;
  localparam int GATE_DRIVE_NS  = 4000;
  localparam int GATE_DRIVE_CYC = GATE_DRIVE_NS * CLK_MHZ / 1000;

  typedef logic [10:0] dmscr_dg_t;

  function automatic dmscr_dg_t dmscr_dg_cycles(input logic [1:0] code);
    case (code)
      2'h0:    dmscr_dg_cycles = dmscr_dg_t'(OV_DG0_US * CLK_MHZ);
      2'h1:    dmscr_dg_cycles = dmscr_dg_t'(OV_DG1_US * CLK_MHZ);
      2'h2:    dmscr_dg_cycles = dmscr_dg_t'(OV_DG2_US * CLK_MHZ);
      default: dmscr_dg_cycles = dmscr_dg_t'(OV_DG3_US * CLK_MHZ);
    endcase
  endfunction : dmscr_dg_cycles

endpackage : dmscr_pkg
`default_nettype wire

// ==== logic/dmscr_blank_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface dmscr_blank_if;
  logic [2:0] trigger_sel;
  logic [2:0] duration;
  logic [7:0] bridge_switch;
  logic       blank;

  modport cfg (output trigger_sel, output duration,
               output bridge_switch, input blank);
  modport timer (input trigger_sel, input duration,
                 input bridge_switch, output blank);
endinterface : dmscr_blank_if
`default_nettype wire

// ==== logic/dmscr_fault_mon.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmscr_fault_mon
  import dmscr_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire logic      cond,
  input  wire logic      auto_mode,
  input  wire logic      warn_only,
  input  wire logic      disabled,
  input  wire dmscr_dg_t dg_cycles,
  input  wire logic      clear,
  output var  logic      fault,
  output var  logic      warn
);

  dmscr_dg_t cnt;
  logic      qualified;

  // ------------------------------------------------------------
  // Deglitch
  // ------------------------------------------------------------
  assign qualified = cond && (cnt >= dg_cycles);

  always_ff @(posedge clk) begin
    if (srst || !cond || disabled) begin
      cnt <= '0;
    end else if (cnt < dg_cycles) begin
      cnt <= cnt + 11'h001;
    end
  end

  // ------------------------------------------------------------
  // Fault and warning
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || disabled) begin
      fault <= 1'b0;
      warn  <= 1'b0;
    end else begin
      warn <= qualified && warn_only;
      if (qualified && !warn_only) begin
        fault <= 1'b1;
      end else if (auto_mode && !cond) begin
        fault <= 1'b0;
      end else if (clear) begin
        fault <= 1'b0;
      end
    end
  end

endmodule : dmscr_fault_mon
`default_nettype wire

// ==== logic/dmscr_blank_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmscr_blank_timer
  import dmscr_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  dmscr_blank_if.timer bif
);

  logic [11:0] cnt;
  logic        trig;
  logic [11:0] next_len;

  // ------------------------------------------------------------
  // Trigger and length
  // ------------------------------------------------------------
  assign trig = bif.bridge_switch[bif.trigger_sel];
  assign next_len = 12'((16'(GATE_DRIVE_CYC)
                    * (16'(bif.duration) + 16'h0001)) >> 3);

  always_ff @(posedge clk) begin
    if (srst || bif.duration == 3'h0) begin
      cnt       <= '0;
      bif.blank <= 1'b0;
    end else if (trig) begin
      cnt       <= next_len - 12'h001;
      bif.blank <= 1'b1;
    end else if (cnt != 12'h000) begin
      cnt <= cnt - 12'h001;
    end else begin
      bif.blank <= 1'b0;
    end
  end

endmodule : dmscr_blank_timer
`default_nettype wire

// ==== logic/dmscr_regs.sv ====
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dmscr_regs
  import dmscr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rd_data,
  input  wire logic       supply_uv_cond,
  input  wire logic       supply_ov_cond,
  input  wire logic       pump_uv_cond,
  input  wire logic [7:0] bridge_switch,
  output var  logic [7:0] diag_source_drive,
  output var  logic       supply_overvolt_threshold,
  output var  logic       pump_undervolt_threshold,
  output var  logic       amp1_ref_divider,
  output var  logic [1:0] amp1_gain_sel,
  output var  logic       amp2_ref_divider,
  output var  logic [1:0] amp2_gain_sel,
  output var  logic       supply_uv_fault,
  output var  logic       supply_ov_fault,
  output var  logic       supply_ov_warning,
  output var  logic       pump_uv_fault,
  output var  logic       amp1_blank,
  output var  logic       irq
);

  // ------------------------------------------------------------
  // Decode helper
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] diag_source_enable_hi;
  logic [7:0] supply_monitor_config;
  logic [7:0] shunt_amp_gain_ref;
  logic [7:0] shunt_amp1_blanking;
  logic       offline_diag_global_en;
  logic       fault_clear;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] fault_prev;
  logic [2:0] sync1;
  logic [2:0] sync2;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  logic       wr_diag;
  logic       wr_supply;
  logic       wr_gain;
  logic       wr_blank;
  logic       wr_ctrl;
  logic       wr_irq_st;
  logic       wr_irq_mask;

  assign wr_diag     = wr_en && hit(addr, OFF_DIAG_SRC);
  assign wr_supply   = wr_en && hit(addr, OFF_SUPPLY_MON);
  assign wr_gain     = wr_en && hit(addr, OFF_AMP_GAIN);
  assign wr_blank    = wr_en && hit(addr, OFF_AMP1_BLANK);
  assign wr_ctrl     = wr_en && hit(addr, OFF_CONTROL);
  assign wr_irq_st   = wr_en && hit(addr, OFF_IRQ_STATUS);
  assign wr_irq_mask = wr_en && hit(addr, OFF_IRQ_MASK);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      diag_source_enable_hi <= RST_DIAG_SRC;
    end else if (wr_diag) begin
      diag_source_enable_hi <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      supply_monitor_config <= RST_SUPPLY_MON;
    end else if (wr_supply) begin
      supply_monitor_config <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shunt_amp_gain_ref <= RST_AMP_GAIN;
    end else if (wr_gain) begin
      shunt_amp_gain_ref <= wr_data & AMP_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shunt_amp1_blanking <= RST_AMP1_BLANK;
    end else if (wr_blank) begin
      shunt_amp1_blanking <= wr_data & BLANK_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      offline_diag_global_en <= RST_CONTROL[CTRL_DIAG_EN_BIT];
      fault_clear            <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        offline_diag_global_en <= wr_data[CTRL_DIAG_EN_BIT];
      end
      fault_clear <= wr_ctrl && wr_data[CTRL_FAULT_CLR_BIT];
    end
  end

  // ------------------------------------------------------------
  // Analog setting outputs
  // ------------------------------------------------------------
  logic [7:0] next_diag_drive;

  assign next_diag_drive = diag_source_enable_hi
                         & {8{offline_diag_global_en}};

  always_ff @(posedge clk) begin
    if (srst) begin
      diag_source_drive <= 8'h00;
    end else begin
      diag_source_drive <= next_diag_drive;
    end
  end

  assign supply_overvolt_threshold =
    supply_monitor_config[SUPPLY_OV_THR_BIT];
  assign pump_undervolt_threshold =
    supply_monitor_config[PUMP_UV_THR_BIT];
  assign amp1_ref_divider = shunt_amp_gain_ref[AMP1_DIV_BIT];
  assign amp2_ref_divider = shunt_amp_gain_ref[AMP2_DIV_BIT];
  assign amp1_gain_sel =
    shunt_amp_gain_ref[AMP1_GAIN_LSB +: 2];
  assign amp2_gain_sel =
    shunt_amp_gain_ref[AMP2_GAIN_LSB +: 2];

  // ------------------------------------------------------------
  // Comparator synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {pump_uv_cond, supply_ov_cond, supply_uv_cond};
      sync2 <= sync1;
    end
  end

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  logic [1:0] ov_resp;
  logic       uv_auto;
  logic       ov_auto;
  logic       ov_warn;
  logic       ov_off;
  logic       pump_auto;
  dmscr_dg_t  ov_dg;
  dmscr_dg_t  uv_dg;

  assign ov_resp   = supply_monitor_config[SUPPLY_OV_RESP_LSB +: 2];
  assign uv_auto   = supply_monitor_config[SUPPLY_UV_RESP_BIT];
  assign pump_auto = supply_monitor_config[PUMP_UV_RESP_BIT];
  assign ov_auto   = (ov_resp == OV_AUTO);
  assign ov_warn   = (ov_resp == OV_WARN);
  assign ov_off    = (ov_resp == OV_OFF);
  assign ov_dg     = dmscr_dg_cycles(
    supply_monitor_config[SUPPLY_OV_DG_LSB +: 2]);
  assign uv_dg     = dmscr_dg_t'(UV_DG_CYCLES);

  dmscr_fault_mon u_supply_uv (
    .clk       (clk),
    .srst      (srst),
    .cond      (sync2[0]),
    .auto_mode (uv_auto),
    .warn_only (1'b0),
    .disabled  (1'b0),
    .dg_cycles (uv_dg),
    .clear     (fault_clear),
    .fault     (supply_uv_fault),
    .warn      ()
  );

  dmscr_fault_mon u_supply_ov (
    .clk       (clk),
    .srst      (srst),
    .cond      (sync2[1]),
    .auto_mode (ov_auto),
    .warn_only (ov_warn),
    .disabled  (ov_off),
    .dg_cycles (ov_dg),
    .clear     (fault_clear),
    .fault     (supply_ov_fault),
    .warn      (supply_ov_warning)
  );

  dmscr_fault_mon u_pump_uv (
    .clk       (clk),
    .srst      (srst),
    .cond      (sync2[2]),
    .auto_mode (pump_auto),
    .warn_only (1'b0),
    .disabled  (1'b0),
    .dg_cycles (uv_dg),
    .clear     (fault_clear),
    .fault     (pump_uv_fault),
    .warn      ()
  );

  // ------------------------------------------------------------
  // Amplifier 1 blanking
  // ------------------------------------------------------------
  dmscr_blank_if bif ();

  assign bif.trigger_sel =
    shunt_amp1_blanking[BLANK_SEL_LSB +: 3];
  assign bif.duration =
    shunt_amp1_blanking[BLANK_LVL_LSB +: 3];
  assign bif.bridge_switch = bridge_switch;
  assign amp1_blank = bif.blank;

  dmscr_blank_timer u_blank (
    .clk  (clk),
    .srst (srst),
    .bif  (bif.timer)
  );

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  logic [3:0] faults_now;
  logic [3:0] fault_rise;
  logic [3:0] next_irq_status;

  assign faults_now = {pump_uv_fault, supply_ov_warning,
                       supply_ov_fault, supply_uv_fault};
  assign fault_rise = faults_now & ~fault_prev;
  assign next_irq_status = fault_rise
    | (irq_status & ~(wr_irq_st ? wr_data[3:0] : 4'h0));

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_prev <= 4'h0;
      irq_status <= RST_IRQ;
      irq_mask   <= RST_IRQ;
      irq        <= 1'b0;
    end else begin
      fault_prev <= faults_now;
      irq_status <= next_irq_status;
      if (wr_irq_mask) begin
        irq_mask <= wr_data[3:0];
      end
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    case (1'b1)
      hit(addr, OFF_DIAG_SRC):   next_rd_data = diag_source_enable_hi;
      hit(addr, OFF_SUPPLY_MON): next_rd_data = supply_monitor_config;
      hit(addr, OFF_AMP_GAIN):
        next_rd_data = shunt_amp_gain_ref & AMP_WR_MASK;
      hit(addr, OFF_AMP1_BLANK):
        next_rd_data = shunt_amp1_blanking & BLANK_WR_MASK;
      hit(addr, OFF_CONTROL):
        next_rd_data = {7'h00, offline_diag_global_en};
      hit(addr, OFF_FAULT_STAT): next_rd_data = {4'h0, faults_now};
      hit(addr, OFF_IRQ_STATUS): next_rd_data = {4'h0, irq_status};
      hit(addr, OFF_IRQ_MASK):   next_rd_data = {4'h0, irq_mask};
      default:                   next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule : dmscr_regs
`default_nettype wire

// ==== verification/dmscr_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmscr_sva
  import dmscr_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       supply_uv_cond,
  input wire logic [7:0] bridge_switch,
  input wire logic [7:0] diag_source_drive,
  input wire logic       supply_overvolt_threshold,
  input wire logic       pump_undervolt_threshold,
  input wire logic       amp1_ref_divider,
  input wire logic [1:0] amp1_gain_sel,
  input wire logic       amp2_ref_divider,
  input wire logic [1:0] amp2_gain_sel,
  input wire logic       supply_uv_fault,
  input wire logic       supply_ov_fault,
  input wire logic       supply_ov_warning,
  input wire logic       amp1_blank
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // Shadow copies of the written registers
  // ------------------------------------------------------------
  logic [7:0] s24, s25, s26, s27;
  logic       en;
  logic [1:0] clr_q;
  wire  ctl = wr_en && addr == OFF_CONTROL;
  wire  clr = ctl && wr_data[CTRL_FAULT_CLR_BIT];
  wire  [7:0] next_s24 = (wr_en && addr == OFF_DIAG_SRC) ? wr_data : s24;
  wire  [7:0] next_s25 = (wr_en && addr == OFF_SUPPLY_MON) ? wr_data : s25;
  wire  [7:0] next_s26 = (wr_en && addr == OFF_AMP_GAIN) ? wr_data : s26;
  wire  [7:0] next_s27 = (wr_en && addr == OFF_AMP1_BLANK) ? wr_data : s27;
  always_ff @(posedge clk) begin
    s24   <= srst ? RST_DIAG_SRC : next_s24;
    s25   <= srst ? RST_SUPPLY_MON : next_s25;
    s26   <= srst ? RST_AMP_GAIN : next_s26;
    s27   <= srst ? RST_AMP1_BLANK : next_s27;
    en    <= srst ? 1'b0 : (ctl ? wr_data[CTRL_DIAG_EN_BIT] : en);
    clr_q <= srst ? 2'h0 : {clr_q[0], clr};
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_amp_rsvd_zero: assert property (
    $past(rd_en) && $past(addr[7:1]) == 7'h13 |-> rd_data[7:6] == 2'h0)
    else $error("reserved amplifier bits read nonzero");
  chk_diag_gated: assert property (
    diag_source_drive == $past(s24 & {8{en}}))
    else $error("diagnostic drive differs from gated enables");
  chk_thr_follow: assert property (
    {supply_overvolt_threshold, pump_undervolt_threshold} == {s25[2], s25[0]})
    else $error("threshold outputs differ from register");
  chk_amp_fields: assert property (
    {amp1_ref_divider, amp1_gain_sel, amp2_ref_divider, amp2_gain_sel}
      == s26[5:0])
    else $error("amplifier outputs differ from register");
  chk_blank_start: assert property (
    s27[2:0] != 3'h0 && bridge_switch[s27[5:3]] |=> amp1_blank)
    else $error("blanking not started by selected bridge");
  chk_blank_off: assert property (
    $past(s27[2:0]) == 3'h0 |-> !amp1_blank)
    else $error("blanking high with duration code zero");
  chk_ov_off: assert property (
    $past(s25[6:5]) == OV_OFF |-> !supply_ov_fault && !supply_ov_warning)
    else $error("overvoltage reported while disabled");
  chk_uv_rise: assert property (
    $rose(supply_uv_fault) |-> $past(supply_uv_cond, 4))
    else $error("undervoltage fault without condition");
  chk_uv_latched: assert property (
    supply_uv_fault && !s25[7] && !clr && clr_q == 2'h0 |=> supply_uv_fault)
    else $error("latched undervoltage fault released without clear");
endmodule : dmscr_sva
bind dmscr_regs dmscr_sva u_sva (
  .clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .supply_uv_cond,
  .bridge_switch, .diag_source_drive, .supply_overvolt_threshold,
  .pump_undervolt_threshold, .amp1_ref_divider, .amp1_gain_sel,
  .amp2_ref_divider, .amp2_gain_sel, .supply_uv_fault, .supply_ov_fault,
  .supply_ov_warning, .amp1_blank);
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dmscr_pkg::*;
  logic clk = 0, srst = 1, wr_en = 0, rd_en = 0;
  logic supply_uv_cond = 0, supply_ov_cond = 0, pump_uv_cond = 0;
  logic [7:0] addr = 0, wr_data = 0, bridge_switch = 0;
  wire logic [7:0] rd_data, diag_source_drive;
  wire logic [1:0] amp1_gain_sel, amp2_gain_sel;
  wire logic supply_overvolt_threshold, pump_undervolt_threshold, irq;
  wire logic amp1_ref_divider, amp2_ref_divider, amp1_blank;
  wire logic supply_uv_fault, supply_ov_fault, supply_ov_warning;
  wire logic pump_uv_fault;
  int failures = 0, checked = 0, cyc = 0;
  dmscr_regs dut (.clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .supply_uv_cond, .supply_ov_cond, .pump_uv_cond, .bridge_switch,
    .diag_source_drive, .supply_overvolt_threshold, .pump_undervolt_threshold,
    .amp1_ref_divider, .amp1_gain_sel, .amp2_ref_divider, .amp2_gain_sel,
    .supply_uv_fault, .supply_ov_fault, .supply_ov_warning, .pump_uv_fault,
    .amp1_blank, .irq);
  always #2.5 clk = ~clk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    wr_en <= 1; addr <= a; wr_data <= d;
    @(posedge clk);
    wr_en <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp, input string m);
    @(posedge clk);
    rd_en <= 1; addr <= a;
    @(posedge clk);
    rd_en <= 0;
    #1;
    chk(rd_data, exp, m);
  endtask : rd
  task automatic cond(input int m, input logic v);
    @(posedge clk);
    if (m == 0) supply_uv_cond <= v;
    else if (m == 1) pump_uv_cond <= v;
    else supply_ov_cond <= v;
  endtask : cond
  task automatic blen(input int b, lo, hi);
    int n;
    n = 0;
    @(posedge clk);
    bridge_switch <= 8'h01 << b;
    @(posedge clk);
    bridge_switch <= 8'h00;
    idle(1);
    while (amp1_blank === 1'b1 && n < 2000) begin
      n++;
      idle(1);
    end
    chk({7'h0, n >= lo && n <= hi}, 8'h01, "blank length");
  endtask : blen
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(OFF_DIAG_SRC, 8'h00, "rst diag");
    rd(OFF_SUPPLY_MON, 8'h14, "rst mon");
    rd(OFF_AMP_GAIN, 8'h09, "rst amp");
    rd(OFF_AMP1_BLANK, 8'h00, "rst blank");
    for (int i = 0; i < 4; i++) wr(OFF_DIAG_SRC + 8'(i), 8'hFF);
    wr(8'h30, 8'hFF);
    rd(OFF_DIAG_SRC, 8'hFF, "rw diag");
    rd(OFF_SUPPLY_MON, 8'hFF, "rw mon");
    rd(OFF_AMP_GAIN, 8'h3F, "rw amp");
    rd(OFF_AMP1_BLANK, 8'h3F, "rw blank");
    rd(8'h30, 8'h00, "unmapped");
    wr(OFF_SUPPLY_MON, 8'h05);
    chk({6'h0, supply_overvolt_threshold, pump_undervolt_threshold}, 8'h03,
        "thr hi");
    wr(OFF_SUPPLY_MON, 8'h10);
    chk({6'h0, supply_overvolt_threshold, pump_undervolt_threshold}, 8'h00,
        "thr lo");
    for (int g = 0; g < 4; g++) begin
      wr(OFF_AMP_GAIN, {2'h0, g[0], g[1:0], ~g[0], ~g[1:0]});
      chk({2'h0, amp1_ref_divider, amp1_gain_sel, amp2_ref_divider,
           amp2_gain_sel}, {2'h0, g[0], g[1:0], ~g[0], ~g[1:0]}, "amp");
    end
  endtask : t_regs
  task automatic t_diag;
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_DIAG_SRC, 8'hA5);
    idle(2);
    chk(diag_source_drive, 8'h00, "diag off");
    wr(OFF_CONTROL, 8'h01);
    idle(2);
    chk(diag_source_drive, 8'hA5, "diag on");
    wr(OFF_DIAG_SRC, 8'h5A);
    idle(2);
    chk(diag_source_drive, 8'h5A, "diag new");
    wr(OFF_CONTROL, 8'h00);
    idle(2);
    chk(diag_source_drive, 8'h00, "diag gate");
  endtask : t_diag
  task automatic t_blank;
    for (int s = 0; s < 8; s++) begin
      wr(OFF_AMP1_BLANK, {2'h0, 3'(s), 3'h1});
      blen((s + 1) % 8, 0, 0);
      blen(s, 199, 201);
    end
    wr(OFF_AMP1_BLANK, 8'h07);
    blen(0, 799, 801);
    wr(OFF_AMP1_BLANK, 8'h00);
    blen(0, 0, 0);
  endtask : t_blank
  task automatic t_uv(input int m, input logic au);
    wr(OFF_SUPPLY_MON, m ? {6'h05, au, 1'b0} : {au, 7'h14});
    cond(m, 1);
    idle(6);
    chk({7'h0, m ? pump_uv_fault : supply_uv_fault}, 8'h01,
        "uv set");
    cond(m, 0);
    idle(6);
    chk({7'h0, m ? pump_uv_fault : supply_uv_fault}, {7'h0, !au},
        "uv hold");
    wr(OFF_CONTROL, 8'h02);
    idle(3);
    chk({7'h0, m ? pump_uv_fault : supply_uv_fault}, 8'h00, "uv clr");
  endtask : t_uv
  task automatic t_ov(input logic [1:0] md);
    int n;
    n = (OV_DG0_US * CLK_MHZ) << md;
    wr(OFF_SUPPLY_MON, {1'b0, md, md, 3'h4});
    cond(2, 1);
    idle(n - 50);
    chk({6'h0, supply_ov_fault, supply_ov_warning}, 8'h00, "ov early");
    idle(60);
    chk({6'h0, supply_ov_fault, supply_ov_warning},
        {6'h0, md < 2'h2, md == 2'h2}, "ov mode");
    cond(2, 0);
    idle(6);
    chk({7'h0, supply_ov_fault}, {7'h0, md == 2'h0}, "ov hold");
    wr(OFF_CONTROL, 8'h02);
    idle(3);
  endtask : t_ov
  task automatic t_irq;
    wr(OFF_SUPPLY_MON, 8'h14);
    wr(OFF_IRQ_MASK, 8'h00);
    wr(OFF_IRQ_STATUS, 8'h0F);
    rd(OFF_IRQ_STATUS, 8'h00, "irq clr");
    cond(0, 1);
    idle(6);
    chk({7'h0, irq}, 8'h00, "irq masked");
    rd(OFF_IRQ_STATUS, 8'h01, "irq stat");
    wr(OFF_IRQ_MASK, 8'h01);
    idle(2);
    chk({7'h0, irq}, 8'h01, "irq on");
    cond(0, 0);
    idle(6);
    wr(OFF_CONTROL, 8'h02);
    wr(OFF_IRQ_STATUS, 8'h01);
    idle(2);
    chk({7'h0, irq}, 8'h00, "irq off");
  endtask : t_irq
  task automatic t_rst;
    wr(OFF_CONTROL, 8'h01);
    wr(OFF_DIAG_SRC, 8'h3C);
    wr(OFF_SUPPLY_MON, 8'h01);
    @(posedge clk);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    idle(2);
    chk(diag_source_drive, 8'h00, "rst drive");
    chk({6'h0, supply_overvolt_threshold, pump_undervolt_threshold}, 8'h02,
        "rst thr");
    chk({7'h0, irq}, 8'h00, "rst irq");
    rd(OFF_DIAG_SRC, 8'h00, "rst diag2");
    rd(OFF_CONTROL, 8'h00, "rst ctrl");
    rd(OFF_IRQ_MASK, 8'h00, "rst mask");
  endtask : t_rst
  initial begin
    repeat (16) @(posedge clk);
    srst <= 0;
    t_regs();
    t_diag();
    t_blank();
    for (int i = 0; i < 4; i++) t_uv(i / 2, i[0]);
    for (int i = 0; i < 4; i++) t_ov(2'(i));
    t_irq();
    t_rst();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
